// ---- design/frame_decoder_pkg.sv ----
// Address map, window bounds and bus widths for the peripheral frame decoder
package frame_decoder_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  // Frame zero windows (16-bit word addresses)
  localparam logic [21:0] EMU_LO = 22'h000880;
  localparam logic [21:0] EMU_HI = 22'h0009FF;
  localparam logic [21:0] FLASH_LO = 22'h000A80;
  localparam logic [21:0] FLASH_HI = 22'h000ADF;
  localparam logic [21:0] SECURE_LO = 22'h000AE0;
  localparam logic [21:0] SECURE_HI = 22'h000AEF;
  localparam logic [21:0] CONV_LO = 22'h000B00;
  localparam logic [21:0] CONV_HI = 22'h000B1F;
  localparam logic [21:0] EXTIF_LO = 22'h000B20;
  localparam logic [21:0] EXTIF_HI = 22'h000B3F;
  localparam logic [21:0] TIMER_LO = 22'h000C00;
  localparam logic [21:0] TIMER_HI = 22'h000C3F;
  localparam logic [21:0] IRQCTL_LO = 22'h000CE0;
  localparam logic [21:0] IRQCTL_HI = 22'h000CFF;
  localparam logic [21:0] VECTOR_LO = 22'h000D00;
  localparam logic [21:0] VECTOR_HI = 22'h000DFF;
  localparam logic [21:0] DMAREG_LO = 22'h001000;
  localparam logic [21:0] DMAREG_HI = 22'h0011FF;
  // Frame one windows
  localparam logic [21:0] CANA_LO = 22'h006000;
  localparam logic [21:0] CANB_HI = 22'h0063FF;
  localparam logic [21:0] PWM_BASE = 22'h006800;
  localparam logic [21:0] PWM_SPAN = 22'h000040;
  localparam int PWM_COUNT = 6;
  localparam logic [21:0] CAP_LO = 22'h006A00;
  localparam logic [21:0] CAP_HI = 22'h006ABF;
  localparam logic [21:0] QEP_LO = 22'h006B00;
  localparam logic [21:0] QEP_HI = 22'h006B7F;
  localparam logic [21:0] GPIO_LO = 22'h006F80;
  localparam logic [21:0] GPIO_HI = 22'h006FFF;
  // Frame two windows
  localparam logic [21:0] SYS_LO = 22'h007010;
  localparam logic [21:0] SYS_HI = 22'h00702F;
  localparam logic [21:0] SPI_LO = 22'h007040;
  localparam logic [21:0] SCIA_HI = 22'h00705F;
  localparam logic [21:0] XINT_LO = 22'h007070;
  localparam logic [21:0] XINT_HI = 22'h00707F;
  localparam logic [21:0] ADC_LO = 22'h007100;
  localparam logic [21:0] ADC_HI = 22'h00711F;
  localparam logic [21:0] SCIB_LO = 22'h007750;
  localparam logic [21:0] SCIB_HI = 22'h00775F;
  localparam logic [21:0] SCIC_LO = 22'h007770;
  localparam logic [21:0] SCIC_HI = 22'h00777F;
  localparam logic [21:0] I2C_LO = 22'h007900;
  localparam logic [21:0] I2C_HI = 22'h00793F;
  // Frame three windows
  localparam logic [21:0] SER_LO = 22'h005000;
  localparam logic [21:0] SER_HI = 22'h00507F;
  typedef enum logic [2:0] {
    FRAME_NONE,
    FRAME_ZERO,
    FRAME_ONE,
    FRAME_TWO,
    FRAME_THREE
  } frame_e;
endpackage

// ---- design/peripheral_frame_decoder.sv ----
// Peripheral frame decoder with write-protection gate
// What this block does
// R1: Splits peripheral space into four frames, each routed to its own segment.
// R2: Frame zero windows go straight to the processor memory bus port.
// R3: Frame one accesses leave on a 32-bit peripheral bus.
// R4: Frame two accesses leave on a 16-bit peripheral bus.
// R5: Frame three is a 32-bit bus reachable by DMA and processor.
// R6: Frame zero accepts 16-bit and 32-bit processor accesses.
// R7: Writes to protected windows are dropped until the unlock instruction runs.
// R8: The relock instruction restores write blocking on protected windows.
// R9: Emulation, security and vector table windows are write-protected.
// R10: Duplicate converter window is read-only, zero-wait, unprotected.
// R11: Flash control window also blocked while the security module is locked.
// R12: Frame one decodes six consecutive 64-word modulator windows.
// R13: Interrupt expansion control registers are writable without unlock.
// R14: Unmapped addresses select nothing; writes there have no effect.
`timescale 1ns/10ps
module peripheral_frame_decoder
  import frame_decoder_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor access
  input wire logic cpu_req_i,
  input wire logic cpu_we_i,
  input wire logic cpu_wide_i,
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic [DATA_W-1:0] cpu_wdata_i,
  // DMA access, frame three only
  input wire logic dma_req_i,
  input wire logic dma_we_i,
  input wire logic [ADDR_W-1:0] dma_addr_i,
  input wire logic [DATA_W-1:0] dma_wdata_i,
  // Protection control
  input wire logic protect_unlock_instruction_i,
  input wire logic protect_relock_instruction_i,
  input wire logic code_security_module_locked_i,
  // Frame zero memory bus
  output logic f0_sel_o,
  output logic f0_we_o,
  output logic f0_wide_o,
  output logic f0_zero_wait_o,
  output logic [ADDR_W-1:0] f0_addr_o,
  output logic [DATA_W-1:0] f0_wdata_o,
  // Frame one 32-bit bus
  output logic f1_sel_o,
  output logic f1_we_o,
  output logic [PWM_COUNT-1:0] f1_pwm_sel_o,
  output logic [ADDR_W-1:0] f1_addr_o,
  output logic [DATA_W-1:0] f1_wdata_o,
  // Frame two 16-bit bus
  output logic f2_sel_o,
  output logic f2_we_o,
  output logic [ADDR_W-1:0] f2_addr_o,
  output logic [HALF_W-1:0] f2_wdata_o,
  // Frame three 32-bit DMA-capable bus
  output logic f3_sel_o,
  output logic f3_we_o,
  output logic f3_from_dma_o,
  output logic [ADDR_W-1:0] f3_addr_o,
  output logic [DATA_W-1:0] f3_wdata_o,
  // Status
  output logic unlocked_o,
  output logic blocked_o
);

  // ==========================================================
  // Address decode
  function automatic logic in_win(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] lo,
                                  logic [ADDR_W-1:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  frame_e cpu_frame;
  logic hit_flash, hit_conv, hit_prot, hit_irqctl;
  logic [PWM_COUNT-1:0] pwm_hit;
  logic dma_f3;

  // R12: modulator windows
  for (genvar g = 0; g < PWM_COUNT; g++) begin : g_pwm
    localparam logic [ADDR_W-1:0] LO = PWM_BASE + ADDR_W'(g) * PWM_SPAN;
    assign pwm_hit[g] = in_win(cpu_addr_i, LO, LO + PWM_SPAN - 22'h000001);
  end

  assign hit_flash = in_win(cpu_addr_i, FLASH_LO, FLASH_HI);
  assign hit_conv = in_win(cpu_addr_i, CONV_LO, CONV_HI);
  assign hit_irqctl = in_win(cpu_addr_i, IRQCTL_LO, IRQCTL_HI);
  // R9: protected windows
  assign hit_prot = in_win(cpu_addr_i, EMU_LO, EMU_HI) || hit_flash
                 || in_win(cpu_addr_i, SECURE_LO, SECURE_HI)
                 || in_win(cpu_addr_i, VECTOR_LO, VECTOR_HI)
                 || in_win(cpu_addr_i, DMAREG_LO, DMAREG_HI);
  assign dma_f3 = dma_req_i && in_win(dma_addr_i, SER_LO, SER_HI);

  // Frame zero first, so a protected window can never leak to another frame
  // R1: frame selection
  always_comb begin
    if (hit_prot || hit_conv || hit_irqctl
        || in_win(cpu_addr_i, EXTIF_LO, EXTIF_HI)
        || in_win(cpu_addr_i, TIMER_LO, TIMER_HI)) begin
      cpu_frame = FRAME_ZERO;
    end else if (in_win(cpu_addr_i, CANA_LO, CANB_HI) || (|pwm_hit)
        || in_win(cpu_addr_i, CAP_LO, CAP_HI) || in_win(cpu_addr_i, QEP_LO, QEP_HI)
        || in_win(cpu_addr_i, GPIO_LO, GPIO_HI)) begin
      cpu_frame = FRAME_ONE;
    end else if (in_win(cpu_addr_i, SYS_LO, SYS_HI)
        || in_win(cpu_addr_i, SPI_LO, SCIA_HI) || in_win(cpu_addr_i, XINT_LO, XINT_HI)
        || in_win(cpu_addr_i, ADC_LO, ADC_HI) || in_win(cpu_addr_i, SCIB_LO, SCIB_HI)
        || in_win(cpu_addr_i, SCIC_LO, SCIC_HI) || in_win(cpu_addr_i, I2C_LO, I2C_HI)) begin
      cpu_frame = FRAME_TWO;
    end else if (in_win(cpu_addr_i, SER_LO, SER_HI)) begin
      cpu_frame = FRAME_THREE;
    end else begin
      // R14: unmapped
      cpu_frame = FRAME_NONE;
    end
  end

  // ==========================================================
  // Write-protection gate
  logic unlocked_q;
  logic wr_block;

  // R7: unlock opens, R8: relock closes; relock wins if both fire
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlocked_q <= 1'b0;
    end else if (protect_relock_instruction_i) begin
      unlocked_q <= 1'b0;
    end else if (protect_unlock_instruction_i) begin
      unlocked_q <= 1'b1;
    end
  end

  // R7: drop protected writes while locked
  // R11: flash also needs the security module unlocked
  // R10: converter copy never takes writes
  // R13: interrupt control is outside hit_prot, so never gated
  assign wr_block = cpu_we_i && ((hit_prot && !unlocked_q)
                  || (hit_flash && code_security_module_locked_i) || hit_conv);

  // ==========================================================
  // Registered segment outputs
  logic cpu_go;
  assign cpu_go = cpu_req_i && !(cpu_we_i && wr_block);

  // R2: frame zero on the memory bus; R6: width passes through
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f0_sel_o <= 1'b0;
      f0_we_o <= 1'b0;
      f0_wide_o <= 1'b0;
      f0_zero_wait_o <= 1'b0;
      f0_addr_o <= '0;
      f0_wdata_o <= '0;
    end else begin
      f0_sel_o <= cpu_go && (cpu_frame == FRAME_ZERO);
      f0_we_o <= cpu_we_i && !wr_block;
      f0_wide_o <= cpu_wide_i;
      // R10: zero-wait flag for converter copy
      f0_zero_wait_o <= cpu_req_i && hit_conv;
      f0_addr_o <= cpu_addr_i;
      f0_wdata_o <= cpu_wdata_i;
    end
  end

  // R3: frame one 32-bit segment
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f1_sel_o <= 1'b0;
      f1_we_o <= 1'b0;
      f1_pwm_sel_o <= '0;
      f1_addr_o <= '0;
      f1_wdata_o <= '0;
    end else begin
      f1_sel_o <= cpu_go && (cpu_frame == FRAME_ONE);
      f1_we_o <= cpu_we_i;
      f1_pwm_sel_o <= (cpu_req_i && cpu_frame == FRAME_ONE) ? pwm_hit : '0;
      f1_addr_o <= cpu_addr_i;
      f1_wdata_o <= cpu_wdata_i;
    end
  end

  // R4: frame two carries the low half-word only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f2_sel_o <= 1'b0;
      f2_we_o <= 1'b0;
      f2_addr_o <= '0;
      f2_wdata_o <= '0;
    end else begin
      f2_sel_o <= cpu_go && (cpu_frame == FRAME_TWO);
      f2_we_o <= cpu_we_i;
      f2_addr_o <= cpu_addr_i;
      f2_wdata_o <= cpu_wdata_i[HALF_W-1:0];
    end
  end

  // No queue: a DMA request that loses the cycle must be retried
  // R5: frame three, processor first, DMA when processor is elsewhere
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      f3_sel_o <= 1'b0;
      f3_we_o <= 1'b0;
      f3_from_dma_o <= 1'b0;
      f3_addr_o <= '0;
      f3_wdata_o <= '0;
    end else if (cpu_req_i && cpu_frame == FRAME_THREE) begin
      f3_sel_o <= 1'b1;
      f3_we_o <= cpu_we_i;
      f3_from_dma_o <= 1'b0;
      f3_addr_o <= cpu_addr_i;
      f3_wdata_o <= cpu_wdata_i;
    end else begin
      f3_sel_o <= dma_f3;
      f3_we_o <= dma_we_i;
      f3_from_dma_o <= dma_f3;
      f3_addr_o <= dma_addr_i;
      f3_wdata_o <= dma_wdata_i;
    end
  end

  // Status pulse so software can spot a dropped write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blocked_o <= 1'b0;
    end else begin
      blocked_o <= cpu_req_i && wr_block;
    end
  end
  assign unlocked_o = unlocked_q;

  // ==========================================================
  // Assertions
  // Implication checks look one edge after their trigger; chk_pwm_onehot and chk_one_frame check every edge
  chk_locked_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    cpu_req_i && cpu_we_i && hit_prot && !unlocked_q |=> !f0_sel_o && blocked_o)
    else $error("protected write passed while locked");
  chk_relock_closes: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
    protect_relock_instruction_i |=> !unlocked_o)
    else $error("relock did not close gate");
  chk_unlock_opens: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    protect_unlock_instruction_i && !protect_relock_instruction_i |=> unlocked_o)
    else $error("unlock did not open gate");
  chk_vector_prot: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
    cpu_req_i && cpu_we_i && in_win(cpu_addr_i, VECTOR_LO, VECTOR_HI) && unlocked_q
    |=> f0_sel_o && f0_we_o)
    else $error("unlocked vector write lost");
  chk_conv_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
    cpu_req_i && hit_conv |=> f0_zero_wait_o && !(f0_sel_o && f0_we_o))
    else $error("converter copy write or wait wrong");
  chk_flash_csm: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    cpu_req_i && cpu_we_i && hit_flash && code_security_module_locked_i |=> !f0_sel_o)
    else $error("flash write passed while secure locked");
  chk_pwm_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    $onehot0(f1_pwm_sel_o) && (!(|f1_pwm_sel_o) || f1_sel_o))
    else $error("modulator select not one-hot");
  chk_irqctl_free: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    cpu_req_i && cpu_we_i && hit_irqctl && !unlocked_q |=> f0_sel_o && f0_we_o)
    else $error("interrupt control write blocked");
  chk_unmapped_none: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
    cpu_req_i && cpu_frame == FRAME_NONE && !dma_f3
    |=> !(f0_sel_o || f1_sel_o || f2_sel_o || f3_sel_o))
    else $error("unmapped address selected a frame");
  chk_one_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
    $onehot0({f0_sel_o, f1_sel_o, f2_sel_o}))
    else $error("more than one processor frame selected");
  chk_f2_width: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4
    cpu_req_i && cpu_frame == FRAME_TWO
    |=> f2_sel_o && f2_wdata_o == $past(cpu_wdata_i[HALF_W-1:0]))
    else $error("frame two data wrong");
  chk_dma_f3: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    dma_f3 && !(cpu_req_i && cpu_frame == FRAME_THREE) |=> f3_sel_o && f3_from_dma_o)
    else $error("DMA frame three access lost");
  chk_f3_cpu_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
    cpu_req_i && cpu_frame == FRAME_THREE |=> f3_sel_o && !f3_from_dma_o)
    else $error("processor lost frame three to DMA");
  chk_f1_data: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
    cpu_req_i && cpu_frame == FRAME_ONE |=> f1_sel_o && f1_wdata_o == $past(cpu_wdata_i))
    else $error("frame one data wrong");
  chk_f0_width: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
    cpu_req_i && !cpu_we_i && cpu_frame == FRAME_ZERO
    |=> f0_sel_o && f0_wide_o == $past(cpu_wide_i))
    else $error("frame zero read or width lost");
  chk_flash_open: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    cpu_req_i && cpu_we_i && hit_flash && unlocked_q && !code_security_module_locked_i
    |=> f0_sel_o && f0_we_o)
    else $error("flash write lost with both gates open");
  chk_f0_direct: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R2
    cpu_req_i |=> f0_addr_o == $past(cpu_addr_i) && f0_wdata_o == $past(cpu_wdata_i))
    else $error("frame zero address or data not passed");
  chk_read_free: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
    cpu_req_i && !cpu_we_i |=> !blocked_o)
    else $error("read was refused");

  // ==========================================================
  // Cover points
  cov_unlock_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    unlocked_q && cpu_req_i && cpu_we_i && hit_prot);
  cov_blocked: cover property (@(posedge clk_i) disable iff (!rst_n_i) blocked_o);
  cov_pwm_last: cover property (@(posedge clk_i) disable iff (!rst_n_i) f1_pwm_sel_o[5]);
  cov_dma: cover property (@(posedge clk_i) disable iff (!rst_n_i) f3_from_dma_o);
  cov_relock_tie: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    protect_unlock_instruction_i && protect_relock_instruction_i);

endmodule // peripheral_frame_decoder

// ---- testbench/cpu_dma_master.sv ----
// Processor and DMA master model that issues register accesses
`timescale 1ns/10ps
module cpu_dma_master
  import frame_decoder_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Processor side
  output logic cpu_req_o,
  output logic cpu_we_o,
  output logic cpu_wide_o,
  output logic [ADDR_W-1:0] cpu_addr_o,
  output logic [DATA_W-1:0] cpu_wdata_o,
  // DMA side
  output logic dma_req_o,
  output logic dma_we_o,
  output logic [ADDR_W-1:0] dma_addr_o,
  output logic [DATA_W-1:0] dma_wdata_o
);
  initial begin
    cpu_req_o = 1'b0;
    cpu_we_o = 1'b0;
    cpu_wide_o = 1'b0;
    cpu_addr_o = '0;
    cpu_wdata_o = '0;
    dma_req_o = 1'b0;
    dma_we_o = 1'b0;
    dma_addr_o = '0;
    dma_wdata_o = '0;
  end

  // ==========================================================
  // One request cycle, held across its taking edge
  task automatic access(input logic c, input logic d, input logic we, input logic wide,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    @(negedge clk_i);
    cpu_req_o = c;
    cpu_we_o = we;
    cpu_wide_o = wide;
    cpu_addr_o = a;
    cpu_wdata_o = wd;
    dma_req_o = d;
    dma_we_o = we;
    dma_addr_o = a;
    dma_wdata_o = wd;
    @(posedge clk_i);
    @(negedge clk_i);
    // Released address, data and write lines show inverted values so a stale copy cannot pass
    cpu_req_o = 1'b0;
    dma_req_o = 1'b0;
    cpu_we_o = ~we;
    dma_we_o = ~we;
    cpu_addr_o = ~a;
    dma_addr_o = ~a;
    cpu_wdata_o = ~wd;
    dma_wdata_o = ~wd;
  endtask
endmodule // cpu_dma_master

// ---- testbench/testbench.sv ----
// Self-checking bench for the peripheral frame decoder
`timescale 1ns/10ps
module testbench;
  import frame_decoder_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0;
  logic protect_unlock_instruction_i = 1'b0, protect_relock_instruction_i = 1'b0;
  logic code_security_module_locked_i = 1'b0;
  logic cpu_req_i, cpu_we_i, cpu_wide_i, dma_req_i, dma_we_i;
  logic [ADDR_W-1:0] cpu_addr_i, dma_addr_i, f0_addr_o, f1_addr_o, f2_addr_o, f3_addr_o;
  logic [DATA_W-1:0] cpu_wdata_i, dma_wdata_i, f0_wdata_o, f1_wdata_o, f3_wdata_o;
  logic [HALF_W-1:0] f2_wdata_o;
  logic [PWM_COUNT-1:0] f1_pwm_sel_o;
  logic f0_sel_o, f0_we_o, f0_wide_o, f0_zero_wait_o, f1_sel_o, f1_we_o, f2_sel_o, f2_we_o;
  logic f3_sel_o, f3_we_o, f3_from_dma_o, unlocked_o, blocked_o;
  int bad_count = 0;
  int checks_done = 0;
  localparam logic [31:0] WD = 32'hA5C31E78;
  typedef struct {logic [21:0] a; logic we; logic wide; logic [3:0] sel; logic blk;
    logic [5:0] pwm;} row_s;
  row_s rows [14] = '{
    '{22'h000880, 1'b0, 1'b0, 4'h1, 1'b0, 6'h00}, '{22'h000B10, 1'b0, 1'b1, 4'h1, 1'b0, 6'h00},
    '{22'h006800, 1'b1, 1'b0, 4'h2, 1'b0, 6'h01}, '{22'h006840, 1'b1, 1'b0, 4'h2, 1'b0, 6'h02},
    '{22'h00697F, 1'b1, 1'b0, 4'h2, 1'b0, 6'h20}, '{22'h006980, 1'b0, 1'b0, 4'h0, 1'b0, 6'h00},
    '{22'h007050, 1'b1, 1'b0, 4'h4, 1'b0, 6'h00}, '{22'h005000, 1'b1, 1'b0, 4'h8, 1'b0, 6'h00},
    '{22'h000CE0, 1'b1, 1'b1, 4'h1, 1'b0, 6'h00}, '{22'h000D00, 1'b1, 1'b0, 4'h0, 1'b1, 6'h00},
    '{22'h000B00, 1'b1, 1'b0, 4'h0, 1'b1, 6'h00}, '{22'h000040, 1'b1, 1'b0, 4'h0, 1'b0, 6'h00},
    '{22'h0011FF, 1'b1, 1'b0, 4'h0, 1'b1, 6'h00}, '{22'h000AE0, 1'b1, 1'b0, 4'h0, 1'b1, 6'h00}};

  always #2.5 clk_i = ~clk_i;

  cpu_dma_master i_cpu_dma_master (.clk_i(clk_i), .cpu_req_o(cpu_req_i), .cpu_we_o(cpu_we_i),
    .cpu_wide_o(cpu_wide_i), .cpu_addr_o(cpu_addr_i), .cpu_wdata_o(cpu_wdata_i),
    .dma_req_o(dma_req_i), .dma_we_o(dma_we_i), .dma_addr_o(dma_addr_i),
    .dma_wdata_o(dma_wdata_i));

  peripheral_frame_decoder i_peripheral_frame_decoder (.clk_i, .rst_n_i, .cpu_req_i, .cpu_we_i,
    .cpu_wide_i, .cpu_addr_i, .cpu_wdata_i, .dma_req_i, .dma_we_i, .dma_addr_i, .dma_wdata_i,
    .protect_unlock_instruction_i, .protect_relock_instruction_i, .code_security_module_locked_i,
    .f0_sel_o, .f0_we_o, .f0_wide_o, .f0_zero_wait_o, .f0_addr_o, .f0_wdata_o, .f1_sel_o,
    .f1_we_o, .f1_pwm_sel_o, .f1_addr_o, .f1_wdata_o, .f2_sel_o, .f2_we_o, .f2_addr_o,
    .f2_wdata_o, .f3_sel_o, .f3_we_o, .f3_from_dma_o, .f3_addr_o, .f3_wdata_o, .unlocked_o,
    .blocked_o);

  // ==========================================================
  // Compare and reporting helpers
  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic expect_out(input logic [3:0] sel, input logic blk, input logic [5:0] pwm,
      input logic [21:0] a, input logic wide, input logic we);
    cmpv({f3_sel_o, f2_sel_o, f1_sel_o, f0_sel_o}, sel);
    cmpv(blocked_o, blk);
    if (sel[0]) cmpv({f0_addr_o, f0_wide_o, f0_we_o}, {a, wide, we});
    if (sel[0]) cmpv(f0_wdata_o, WD);
    cmpv(f0_zero_wait_o, a >= CONV_LO && a <= CONV_HI);
    if (sel[1]) cmpv({f1_pwm_sel_o, f1_we_o, f1_addr_o}, {pwm, we, a});
    if (sel[1]) cmpv(f1_wdata_o, WD);
    if (sel[2]) cmpv({f2_addr_o, f2_we_o}, {a, we});
    if (sel[2]) cmpv(f2_wdata_o, WD[15:0]);
    if (sel[3]) cmpv({f3_addr_o, f3_we_o}, {a, we});
    if (sel[3]) cmpv(f3_wdata_o, WD);
  endtask

  task automatic pulse(input logic u, input logic r);
    @(negedge clk_i);
    protect_unlock_instruction_i = u;
    protect_relock_instruction_i = r;
    @(negedge clk_i);
    protect_unlock_instruction_i = 1'b0;
    protect_relock_instruction_i = 1'b0;
  endtask

  task automatic go(input logic c, input logic d, input logic [21:0] a, input logic [3:0] sel,
      input logic blk);
    i_cpu_dma_master.access(c, d, 1'b1, 1'b0, a, WD);
    expect_out(sel, blk, 6'h00, a, 1'b0, 1'b1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_i);
    cmpv({f0_sel_o, f1_sel_o, f2_sel_o, f3_sel_o, unlocked_o, blocked_o}, 0);
    rst_n_i = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      i_cpu_dma_master.access(1'b1, 1'b0, rows[i].we, rows[i].wide, rows[i].a, WD);
      expect_out(rows[i].sel, rows[i].blk, rows[i].pwm, rows[i].a, rows[i].wide,
          rows[i].we);
    end
    $display("test address table done");
    // software opens the gate before protected writes
    pulse(1'b1, 1'b0);
    cmpv(unlocked_o, 1'b1);
    go(1'b1, 1'b0, 22'h000D00, 4'h1, 1'b0);
    code_security_module_locked_i = 1'b1;
    go(1'b1, 1'b0, 22'h000A80, 4'h0, 1'b1);
    code_security_module_locked_i = 1'b0;
    go(1'b1, 1'b0, 22'h000ADF, 4'h1, 1'b0);
    pulse(1'b0, 1'b1);
    go(1'b1, 1'b0, 22'h000880, 4'h0, 1'b1);
    pulse(1'b1, 1'b0);
    pulse(1'b1, 1'b1);
    cmpv(unlocked_o, 1'b0);
    $display("test protection gate done");
    go(1'b0, 1'b1, 22'h00507F, 4'h8, 1'b0);
    cmpv(f3_from_dma_o, 1'b1);
    go(1'b0, 1'b1, 22'h006800, 4'h0, 1'b0);
    go(1'b1, 1'b1, 22'h005040, 4'h8, 1'b0);
    cmpv(f3_from_dma_o, 1'b0);
    $display("test dma path done");
    pulse(1'b1, 1'b0);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    cmpv(unlocked_o, 1'b0);
    rst_n_i = 1'b1;
    go(1'b1, 1'b0, 22'h000DFF, 4'h0, 1'b1);
    $display("test mid-run reset done");
    close_out();
  end

  // Hang guard at 4000 cycles, far beyond the roughly 62 cycles the tests take
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule // testbench
